// [dv/battery_fault_mode_control_tb.sv]
// self-checking bench for the battery fault and mode controller
`timescale 1ns/1ps
module battery_fault_mode_control_tb;
  import bfmc_pkg::*;
  logic        clk_in;
  logic        reset_in;
  logic        link_sel_n, link_clk, link_data, trip;
  logic [5:0]  cmp;
  logic [7:0]  status;
  logic        drain, gate_n, loop_on, gauge, apwr, latch;
  logic [1:0]  ref_sel, r;
  int          bits_sent, bad_count, compares, cycles;
  logic [14:0] exp_q[$];
  event        chk_ev;

  bfmc_ctrl i_bfmc_ctrl (.clk_in(clk_in), .reset_in(reset_in), .link_sel_n_in(link_sel_n), .link_clk_in(link_clk),
    .link_data_in(link_data), .pack_present_in(cmp[5]), .pack_reversed_in(cmp[4]), .cell_ceiling_in(cmp[3]),
    .cell_floor_in(cmp[2]), .hot_limit_in(cmp[1]), .cold_limit_in(cmp[0]), .current_trip_in(trip),
    .fault_status_word_out(status), .drain_switch_drive_out(drain), .gate_drive_n_out(gate_n),
    .charge_loop_on_out(loop_on), .gauge_on_out(gauge), .analog_power_out(apwr), .charge_ref_sel_out(ref_sel));
  bfmc_host_model i_bfmc_host_model (.link_sel_n_out(link_sel_n), .link_clk_out(link_clk),
    .link_data_out(link_data), .bits_sent_out(bits_sent));

  always #25 clk_in = ~clk_in;

  function automatic logic [21:0] cmd(input logic [1:0] md, input logic slp, input logic clr, input logic [1:0] rf);
    logic [21:0] w;
    w = 22'h200000;
    w[22-POS_MODE_LO] = md[0];
    w[22-POS_MODE_HI] = md[1];
    w[22-POS_SLEEP] = slp;
    w[22-POS_CLEAR] = clr;
    w[22-POS_REF_LO] = rf[0];
    w[22-POS_REF_HI] = rf[1];
    return w;
  endfunction : cmd
  function automatic logic [14:0] exp_v(input logic [7:0] st, input logic dr, input logic lp, input logic gg,
                                        input logic pw, input logic [1:0] rf);
    return {st, dr, 1'b1, lp, gg, pw, rf};
  endfunction : exp_v
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask : tick
  task automatic go(input logic [21:0] w);
    i_bfmc_host_model.send(w);
    tick(12);
  endtask : go
  task automatic note_exp(input logic [14:0] v);
    exp_q.push_back(v);
    -> chk_ev;
    tick(1);
  endtask : note_exp
  task automatic check(input logic [14:0] seen, input logic [14:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  always @(chk_ev) begin
    check({status, drain, gate_n, loop_on, gauge, apwr, ref_sel}, exp_q.pop_front());
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    clk_in = 1'b0;
    reset_in = 1'b1;
    cmp = 6'h00;
    trip = 1'b1;
    r = 2'($urandom(32'h2644));
    tick(3);
    reset_in = 1'b0;
    note_exp(exp_v(8'h00, 0, 0, 0, 1, 2'h0));
    cmp = 6'b100000;
    tick(8);
    for (int m = 0; m < 4; m++) begin
      go(cmd(m[1:0], 1'b0, 1'b0, m[1:0]));
      note_exp(exp_v(8'h80, m == 1, m == 2, m == 3, 1'b1, m[1:0]));
    end
    fork
      i_bfmc_host_model.send(cmd(MODE_DRAIN, 1'b0, 1'b0, 2'h1));
      begin
        wait (bits_sent == 4);
        tick(10);
        note_exp(exp_v(8'h80, 1, 0, 0, 1, 2'h3));
      end
    join
    tick(12);
    note_exp(exp_v(8'h80, 1, 0, 0, 1, 2'h1));
    go(cmd(MODE_DRAIN, 1'b1, 1'b0, 2'h0));
    note_exp(exp_v(8'h80, 0, 0, 0, 0, 2'h0));
    // ceiling, floor, hot and cold against discharge and charge
    for (int f = 0; f < 4; f++) begin
      for (int md = 1; md < 3; md++) begin
        cmp = 6'b100000;
        r = 2'($urandom());
        go(cmd(md[1:0], 1'b0, 1'b1, r));
        cmp[f] = 1'b1;
        tick(12);
        latch = (md == 1) ? (f != 3) : (f != 2);
        note_exp(exp_v({2'b10, 4'(1 << f), 1'b0, latch}, md == 1 && !latch, md == 2 && !latch, 0, 1, r));
      end
    end
    cmp = 6'b100000;
    go(cmd(MODE_CHARGE, 1'b0, 1'b0, r));
    note_exp(exp_v(8'h81, 0, 0, 0, 1, r));
    go(cmd(MODE_CHARGE, 1'b0, 1'b1, r));
    note_exp(exp_v(8'h80, 0, 1, 0, 1, r));
    cmp = 6'b110000;
    tick(12);
    note_exp(exp_v(8'hc0, 0, 0, 0, 1, r));
    cmp = 6'b000000;
    tick(12);
    note_exp(exp_v(8'h00, 0, 0, 0, 1, r));
    cmp = 6'b100000;
    trip = 1'b0;
    for (int i = 0; i < 400 && gate_n !== 1'b0; i++) tick(1);
    note_exp({8'h80, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, r});
    trip = 1'b1;
    tick(10);
    note_exp(exp_v(8'h80, 0, 1, 0, 1, r));
    go(cmd(MODE_IDLE, 1'b0, 1'b0, r));
    note_exp(exp_v(8'h80, 0, 0, 0, 1, r));
    give_verdict();
  end
endmodule : battery_fault_mode_control_tb

bind bfmc_ctrl bfmc_ctrl_sva i_bfmc_ctrl_sva (.clk_in(clk_in), .reset_in(reset_in), .link_sel_n_in(link_sel_n_in),
  .pack_present_in(pack_present_in), .pack_reversed_in(pack_reversed_in), .cell_ceiling_in(cell_ceiling_in),
  .cell_floor_in(cell_floor_in), .hot_limit_in(hot_limit_in), .cold_limit_in(cold_limit_in),
  .current_trip_in(current_trip_in), .fault_status_word_out(fault_status_word_out),
  .drain_switch_drive_out(drain_switch_drive_out), .gate_drive_n_out(gate_drive_n_out),
  .charge_loop_on_out(charge_loop_on_out), .gauge_on_out(gauge_on_out), .analog_power_out(analog_power_out),
  .charge_ref_sel_out(charge_ref_sel_out));

// [dv/bfmc_ctrl_sva.sv]
// port-level assertions for the battery fault and mode controller
`timescale 1ns/1ps
module bfmc_ctrl_sva
  import bfmc_pkg::*;
(
  // clock and reset
  input wire logic       clk_in,
  input wire logic       reset_in,
  // watched inputs
  input wire logic       link_sel_n_in,
  input wire logic       pack_present_in,
  input wire logic       pack_reversed_in,
  input wire logic       cell_ceiling_in,
  input wire logic       cell_floor_in,
  input wire logic       hot_limit_in,
  input wire logic       cold_limit_in,
  input wire logic       current_trip_in,
  // watched outputs
  input wire logic [7:0] fault_status_word_out,
  input wire logic       drain_switch_drive_out,
  input wire logic       gate_drive_n_out,
  input wire logic       charge_loop_on_out,
  input wire logic       gauge_on_out,
  input wire logic       analog_power_out,
  input wire logic [1:0] charge_ref_sel_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_tripped;
    fault_status_word_out[ST_FAILSAFE] && !drain_switch_drive_out && !charge_loop_on_out;
  endsequence
  // eight cycles covers the three-flop sync plus the output register
  AST_STATUS_LIVE: assert property ($stable({pack_present_in, pack_reversed_in, cell_ceiling_in, cell_floor_in,
    hot_limit_in, cold_limit_in}) [*8] |-> fault_status_word_out[7:2] == {pack_present_in, pack_reversed_in,
    cell_ceiling_in, cell_floor_in, hot_limit_in, cold_limit_in}) else $error("status flags wrong");
  AST_DRAIN_FAULT: assert property (drain_switch_drive_out && $rose(cell_floor_in) |-> ##[1:8] s_tripped)
    else $error("floor fault left drain on");
  AST_CHARGE_FAULT: assert property (charge_loop_on_out && $rose(hot_limit_in) |-> ##[1:8] s_tripped)
    else $error("hot fault left loop on");
  AST_PACK_BLOCK: assert property ((!pack_present_in || pack_reversed_in) [*8] |->
    !drain_switch_drive_out && !charge_loop_on_out) else $error("loops on without good pack");
  AST_CEIL_BLOCK: assert property (cell_ceiling_in [*8] |-> !charge_loop_on_out)
    else $error("charge on above ceiling");
  AST_FS_HOLD: assert property (link_sel_n_in [*8] ##0 fault_status_word_out[ST_FAILSAFE] |=>
    fault_status_word_out[ST_FAILSAFE]) else $error("fail-safe dropped outside a frame");
  AST_SLEEP_OFF: assert property (!analog_power_out [*2] |-> !drain_switch_drive_out && !charge_loop_on_out
    && !gauge_on_out) else $error("function on while asleep");
  AST_GAUGE_ALONE: assert property (gauge_on_out |-> !drain_switch_drive_out && !charge_loop_on_out)
    else $error("gauge with another mode");
  AST_REF_HOLD: assert property (link_sel_n_in [*8] |=> $stable(charge_ref_sel_out))
    else $error("reference moved outside a frame");
  AST_TRIP_GATE: assert property (current_trip_in [*8] |-> gate_drive_n_out)
    else $error("gate on while tripped");
  AST_LOOP_GATE: assert property (!charge_loop_on_out [*3] |-> gate_drive_n_out)
    else $error("gate on with loop off");
endmodule : bfmc_ctrl_sva

// [dv/bfmc_host_model.sv]
// serial command sender standing in for the controlling processor
`timescale 1ns/1ps
module bfmc_host_model (
  // serial command link
  output logic link_sel_n_out,
  output logic link_clk_out,
  output logic link_data_out,
  // progress through the current frame
  output int   bits_sent_out
);
  initial begin
    link_sel_n_out = 1'b1;
    link_clk_out = 1'b0;
    link_data_out = 1'b0;
    bits_sent_out = 0;
  end
  // link clock runs only inside a frame, phase unrelated to clk_in
  task automatic send(input logic [21:0] word);
    link_sel_n_out = 1'b0;
    bits_sent_out = 0;
    #237;
    for (int i = 21; i >= 0; i--) begin
      link_data_out = word[i];
      #200 link_clk_out = 1'b1;
      bits_sent_out = bits_sent_out + 1;
      #200 link_clk_out = 1'b0;
    end
    #200 link_sel_n_out = 1'b1;
    // data line has no pull, so show the opposite of the last bit
    link_data_out = ~link_data_out;
  endtask : send
endmodule : bfmc_host_model

// [rtl/bfmc_ctrl.sv]
// battery fault latching, mode control, gate flip-flop and duty gating
`timescale 1ns/1ps
module bfmc_ctrl
  import bfmc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // serial command link from the controller
  input  wire logic       link_sel_n_in,
  input  wire logic       link_clk_in,
  input  wire logic       link_data_in,
  // analogue comparator outputs
  input  wire logic       pack_present_in,
  input  wire logic       pack_reversed_in,
  input  wire logic       cell_ceiling_in,
  input  wire logic       cell_floor_in,
  input  wire logic       hot_limit_in,
  input  wire logic       cold_limit_in,
  input  wire logic       current_trip_in,
  // status word for the read-back shifter
  output logic [7:0]      fault_status_word_out,
  // drives to the power stage
  output logic            drain_switch_drive_out,
  output logic            gate_drive_n_out,
  output logic            charge_loop_on_out,
  output logic            gauge_on_out,
  output logic            analog_power_out,
  output logic [1:0]      charge_ref_sel_out
);
  import bfmc_pkg::*;

  // ---------------- input synchronisation
  // link pins share the comparators' synchroniser, so clock and data keep their spacing
  logic [9:0] synced;
  bfmc_sync #(.WIDTH(10)) u_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in ({link_sel_n_in, link_clk_in, link_data_in, pack_present_in,
                pack_reversed_in, cell_ceiling_in, cell_floor_in, hot_limit_in,
                cold_limit_in, current_trip_in}),
    .sync_out (synced)
  );
  logic sel_n;
  logic sclk;
  logic sdata;
  logic present;
  logic reversed;
  logic ceiling;
  logic floor_hit;
  logic hot;
  logic cold;
  logic trip;
  assign {sel_n, sclk, sdata, present, reversed, ceiling, floor_hit, hot, cold, trip} = synced;

  // ---------------- serial command capture
  bfmc_link_e  link_state;
  logic        sclk_q;
  logic        sel_n_q;
  logic [4:0]  bit_pos;
  logic [1:0]  op_select;
  logic        sleep_bit;
  logic [2:0]  gating_ratio_sel;
  logic        latch_clear_bit;
  logic [2:0]  expiry_sel;
  logic [1:0]  charge_ref_sel;
  logic        clear_pulse;
  logic        sclk_rise;
  logic        sel_rise;
  assign sclk_rise = sclk && !sclk_q && !sel_n;
  assign sel_rise  = sel_n && !sel_n_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sclk_q  <= 1'b0;
      sel_n_q <= 1'b1;
    end else begin
      sclk_q  <= sclk;
      sel_n_q <= sel_n;
    end
  end

  // bit_pos names the command bit that the next link clock rise delivers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      link_state <= BFMC_WAIT;
      bit_pos    <= 5'h0;
    end else if (sel_n) begin
      link_state <= BFMC_WAIT;
      bit_pos    <= 5'h0;
    end else if (sclk_rise) begin
      case (link_state)
        BFMC_WAIT: begin
          if (sdata) begin
            link_state <= BFMC_SHIFT;
            bit_pos    <= 5'(POS_MODE_LO);
          end
        end
        BFMC_SHIFT: begin
          if (bit_pos == 5'(CMD_BITS)) begin
            link_state <= BFMC_DONE;
          end else begin
            bit_pos <= bit_pos + 5'h1;
          end
        end
        BFMC_DONE: begin
          link_state <= BFMC_DONE;
        end
        default: begin
          link_state <= BFMC_WAIT;
        end
      endcase
    end
  end

  // each field is taken the moment its bit arrives, so mode changes early
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      op_select        <= MODE_IDLE;
      sleep_bit        <= 1'b0;
      gating_ratio_sel <= 3'h0;
      expiry_sel       <= EXPIRY_RESET;
      charge_ref_sel   <= 2'h0;
    end else if (sclk_rise && link_state == BFMC_SHIFT) begin
      case (bit_pos)
        5'(POS_MODE_LO):    op_select[0]        <= sdata;
        5'(POS_MODE_HI):    op_select[1]        <= sdata;
        5'(POS_SLEEP):      sleep_bit           <= sdata;
        5'(POS_RATIO0):     gating_ratio_sel[0] <= sdata;
        5'(POS_RATIO0 + 1): gating_ratio_sel[1] <= sdata;
        5'(POS_RATIO0 + 2): gating_ratio_sel[2] <= sdata;
        5'(POS_EXPIRY0):    expiry_sel[0]       <= sdata;
        5'(POS_EXPIRY0 + 1): expiry_sel[1]      <= sdata;
        5'(POS_EXPIRY0 + 2): expiry_sel[2]      <= sdata;
        5'(POS_REF_LO):     charge_ref_sel[0]   <= sdata;
        5'(POS_REF_HI):     charge_ref_sel[1]   <= sdata;
        default: begin
        end
      endcase
    end
  end

  // clear bit is held until select rises and fires one clear pulse on arrival
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      latch_clear_bit <= 1'b0;
      clear_pulse     <= 1'b0;
    end else begin
      clear_pulse <= 1'b0;
      if (sel_rise) begin
        latch_clear_bit <= 1'b0;
      end else if (sclk_rise && link_state == BFMC_SHIFT && bit_pos == 5'(POS_CLEAR)) begin
        latch_clear_bit <= sdata;
        clear_pulse     <= sdata;
      end
    end
  end

  // ---------------- common time base
  // one tick drives both the fail-safe timer and the 16-slot duty period
  logic [25:0] presc;
  logic        tick;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      presc <= 26'h0;
      tick  <= 1'b0;
    end else if (presc == 26'(TICK_CYCLES - 1)) begin
      presc <= 26'h0;
      tick  <= 1'b1;
    end else begin
      presc <= presc + 26'h1;
      tick  <= 1'b0;
    end
  end

  // ---------------- fail-safe timer
  logic [14:0] timer_ticks;
  logic [14:0] limit_ticks;
  logic        timeout_flag;
  // limit doubles per code step; bounded by the 320-minute setting
  assign limit_ticks = 15'(BASE_TICKS) << expiry_sel;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      timer_ticks  <= 15'h0;
      timeout_flag <= 1'b0;
    end else if (clear_pulse || latch_clear_bit) begin
      // held at zero for as long as the clear bit stands in this frame
      timer_ticks  <= 15'h0;
      timeout_flag <= 1'b0;
    end else begin
      if (tick && !timeout_flag) begin
        timer_ticks <= timer_ticks + 15'h1;
      end
      if (expiry_sel != EXPIRY_NONE && timer_ticks > limit_ticks) begin
        timeout_flag <= 1'b1;
      end
    end
  end

  // ---------------- fault evaluation
  logic drain_req;
  logic charge_req;
  logic drain_fault;
  logic charge_fault;
  logic failsafe_latched;
  logic timeout_live;
  logic drain_trip;
  logic charge_trip;
  assign drain_req    = !sleep_bit && op_select == MODE_DRAIN;
  assign charge_req   = !sleep_bit && op_select == MODE_CHARGE;
  // discharge ignores the ceiling comparator, charge ignores the floor one
  assign drain_fault  = !present || reversed || floor_hit || hot || cold || timeout_flag;
  assign charge_fault = !present || reversed || ceiling || hot || cold || timeout_flag;
  // the clear zeroes the timer in this cycle, so its old flag must not re-arm the latch
  assign timeout_live = timeout_flag && !clear_pulse;
  assign drain_trip   = drain_req && (floor_hit || hot || cold || timeout_live);
  assign charge_trip  = charge_req && (ceiling || hot || cold || timeout_live);

  // a fault arriving with the clear pulse still latches
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      failsafe_latched <= 1'b0;
    end else if (drain_trip || charge_trip) begin
      failsafe_latched <= 1'b1;
    end else if (clear_pulse) begin
      failsafe_latched <= 1'b0;
    end
  end

  // ---------------- duty ratio generator
  logic [3:0] slot;
  logic       duty_on;
  logic [4:0] on_slots;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      slot <= 4'h0;
    end else if (tick) begin
      slot <= slot + 4'h1;
    end
  end
  // code n on for 2^n of 16 slots; test codes treated as full on
  assign on_slots = (gating_ratio_sel >= RATIO_FULL) ? 5'(SLOTS_PER_PERIOD)
                                                     : (5'h1 << gating_ratio_sel);
  assign duty_on  = ({1'b0, slot} < on_slots);

  // ---------------- 111 kHz oscillator and gate flip-flop
  // the strobe period rounds down to whole cycles, so it runs a little above 111 kHz
  logic [7:0] osc_cnt;
  logic       osc_edge;
  logic       gate_ff;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      osc_cnt  <= 8'h0;
      osc_edge <= 1'b0;
    end else if (osc_cnt == 8'(OSC_CYCLES - 1)) begin
      osc_cnt  <= 8'h0;
      osc_edge <= 1'b1;
    end else begin
      osc_cnt  <= osc_cnt + 8'h1;
      osc_edge <= 1'b0;
    end
  end

  logic loop_run;
  assign loop_run = charge_req && !charge_fault && !failsafe_latched && duty_on;

  // a trip in the same cycle as the set edge wins, keeping the switch off
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      gate_ff <= 1'b0;
    end else if (!loop_run || trip) begin
      gate_ff <= 1'b0;
    end else if (osc_edge) begin
      gate_ff <= 1'b1;
    end
  end

  // ---------------- registered outputs
  // a sleep request drops the drain, charge loop and gauge drives in the same cycle as analogue power; gate drive follows one cycle later
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      drain_switch_drive_out <= 1'b0;
      gate_drive_n_out       <= 1'b1;
      charge_loop_on_out     <= 1'b0;
      gauge_on_out           <= 1'b0;
      analog_power_out       <= 1'b1;
      charge_ref_sel_out     <= 2'h0;
    end else begin
      drain_switch_drive_out <= drain_req && !drain_fault && !failsafe_latched;
      gate_drive_n_out       <= !gate_ff;
      charge_loop_on_out     <= loop_run;
      gauge_on_out           <= !sleep_bit && op_select == MODE_GAUGE;
      analog_power_out       <= !sleep_bit;
      charge_ref_sel_out     <= charge_ref_sel;
    end
  end

  // comparator flags are passed live; only timeout and fail-safe are held
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fault_status_word_out <= 8'h0;
    end else begin
      fault_status_word_out[ST_PRESENT]  <= present;
      fault_status_word_out[ST_REVERSED] <= reversed;
      fault_status_word_out[ST_CEIL]     <= ceiling;
      fault_status_word_out[ST_FLOOR]    <= floor_hit;
      fault_status_word_out[ST_HOT]      <= hot;
      fault_status_word_out[ST_COLD]     <= cold;
      fault_status_word_out[ST_TIMEOUT]  <= timeout_flag;
      fault_status_word_out[ST_FAILSAFE] <= failsafe_latched;
    end
  end
endmodule : bfmc_ctrl

// [rtl/bfmc_pkg.sv]
// constants for the battery fault and mode controller
package bfmc_pkg;
  localparam int          CLK_HZ           = 20000000;
  localparam int          CMD_BITS         = 22;
  // command bit positions, counted from 1 at the start bit
  localparam int          POS_MODE_LO      = 2;
  localparam int          POS_MODE_HI      = 3;
  localparam int          POS_SLEEP        = 13;
  localparam int          POS_RATIO0       = 14;
  localparam int          POS_CLEAR        = 17;
  localparam int          POS_EXPIRY0      = 18;
  localparam int          POS_REF_LO       = 21;
  localparam int          POS_REF_HI       = 22;
  // status word bit positions
  localparam int          ST_PRESENT       = 7;
  localparam int          ST_REVERSED      = 6;
  localparam int          ST_CEIL          = 5;
  localparam int          ST_FLOOR         = 4;
  localparam int          ST_HOT           = 3;
  localparam int          ST_COLD          = 2;
  localparam int          ST_TIMEOUT       = 1;
  localparam int          ST_FAILSAFE      = 0;
  localparam logic [2:0]  EXPIRY_RESET     = 3'h0;
  localparam logic [2:0]  EXPIRY_NONE      = 3'h7;
  localparam logic [2:0]  RATIO_FULL       = 3'h4;
  localparam logic [1:0]  MODE_IDLE        = 2'h0;
  localparam logic [1:0]  MODE_DRAIN       = 2'h1;
  localparam logic [1:0]  MODE_CHARGE      = 2'h2;
  localparam logic [1:0]  MODE_GAUGE       = 2'h3;
  // time base: 42 s duty period split into 16 slots, 2.625 s a tick
  localparam int          TICK_MS          = 2625;
  localparam int          TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
  localparam int          SLOTS_PER_PERIOD = 16;
  // 5 minutes is 300000 ms, about 114.29 ticks, rounded down
  localparam int          BASE_MIN         = 5;
  localparam int          BASE_TICKS       = BASE_MIN * 60000 / TICK_MS;
  localparam int          OSC_KHZ          = 111;
  localparam int          OSC_CYCLES       = CLK_HZ / (OSC_KHZ * 1000);
  localparam int          SYNC_STAGES      = 3;
  typedef enum logic [1:0] {BFMC_WAIT, BFMC_SHIFT, BFMC_DONE} bfmc_link_e;
endpackage : bfmc_pkg

// [rtl/bfmc_sync.sv]
// three-stage input synchroniser; output moves once stages two and three agree
`timescale 1ns/1ps
module bfmc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // asynchronous levels in, clean levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import bfmc_pkg::*;
  logic [WIDTH-1:0] stage_a;
  logic [WIDTH-1:0] stage_b;
  logic [WIDTH-1:0] stage_c;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stage_a <= '0;
      stage_b <= '0;
      stage_c <= '0;
    end else begin
      stage_a <= async_in;
      stage_b <= stage_a;
      stage_c <= stage_b;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          sync_out[i] <= 1'b0;
        end else if (stage_b[i] == stage_c[i]) begin
          sync_out[i] <= stage_c[i];
        end
      end
    end
  endgenerate
endmodule : bfmc_sync
